// ### include/vapc_defs.svh
// Register offsets, field positions, reset values and timing for the valve pilot block
`ifndef VAPC_DEFS_SVH
`define VAPC_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define VAPC_ADDR_W          8
`define VAPC_OFF_CTRL        8'h00
`define VAPC_OFF_SETPT       8'h04
`define VAPC_OFF_LIMIT       8'h08
`define VAPC_OFF_STATUS      8'h0C
`define VAPC_OFF_ODOM        8'h10
`define VAPC_OFF_STROKE      8'h14
`define VAPC_OFF_CLEAR       8'h18

// ==========================================================================
// Control register fields
`define VAPC_CTRL_DUAL       0
`define VAPC_CTRL_PULSE      1
`define VAPC_CTRL_INV0       2
`define VAPC_CTRL_INV1       3
`define VAPC_CTRL_PVBK0      4
`define VAPC_CTRL_PVBK1      5
`define VAPC_CTRL_AUTO0      6
`define VAPC_CTRL_AUTO1      7
`define VAPC_CTRL_W          8
`define VAPC_CTRL_RST        8'hC0

// ==========================================================================
// Setpoint register fields
`define VAPC_SETPT_SP0       0
`define VAPC_SETPT_SP1       1
`define VAPC_SETPT_MAN0      2
`define VAPC_SETPT_MAN1      3
`define VAPC_SETPT_W         4
`define VAPC_SETPT_RST       4'h0

// ==========================================================================
// Clear register fields, stroke limit reset, tick timing
`define VAPC_CLR_ODOM        0
`define VAPC_CLR_ALARM       1
`define VAPC_LIMIT_RST       16'h1388
`define VAPC_CLK_MHZ         250
`define VAPC_TICK_US         1000
`define VAPC_TICK_CYCLES     (`VAPC_TICK_US * `VAPC_CLK_MHZ)

`endif

// ### include/vapc_pkg.sv
// Types shared by the valve pilot block
package vapc_pkg;

	// ======================================================================
	// Decoded valve position from the two limit switches
	typedef enum logic [1:0] {
		VAPC_POS_MOVING = 2'b00,
		VAPC_POS_CLOSED = 2'b01,
		VAPC_POS_OPENED = 2'b10,
		VAPC_POS_BADADJ = 2'b11
	} vapc_pos_t;

endpackage : vapc_pkg

// ### include/vapc_pin_if.sv
// Raw pin levels and their synchronised copies between the top and the synchroniser
`timescale 1ns/1ps

interface vapc_pin_if #(
	parameter int W = 5
);
	logic [W-1:0] raw;   // Levels straight from the pins
	logic [W-1:0] sync;  // Levels after two flip-flops

	// Synchroniser side
	modport sync_side (input raw, output sync);
	// Block logic side
	modport user_side (output raw, input sync);
endinterface : vapc_pin_if

// ### hw/vapc_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps

module vapc_sync #(
	parameter int W = 5
) (
	input  wire logic         core_clk_in,
	input  wire logic         rst_in,
	vapc_pin_if.sync_side     pins
);

	logic [W-1:0] stage1_r;  // First stage, read only by the second
	logic [W-1:0] stage2_r;  // Second stage, safe to use

	// ======================================================================
	// Synchroniser chain
	// Stage one may go metastable, so nothing but stage two looks at it
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= pins.raw;
			stage2_r <= stage1_r;
		end
	end

	assign pins.sync = stage2_r;

endmodule : vapc_sync

// ### hw/vapc_top.sv
// Valve actuator pilot control: coil drive, position readback, odometer and stroke timer
//
// What this block does
// - Single coil: block one drives both coils
// - Auto output follows setpoint, optionally inverted
// - Dual coil: opposite outputs steer, equal hold
// - Pulse mode drops coil after stroke limit, in dual coil only
// - Constant mode holds coil until new outputs
// - Upper switch closed flag, lower opened flag
// - Readbacks mirror upper and lower switches
// - Readback pair decodes moving, closed, opened, bad
// - Readback copied to process value, optional backcalc
// - Normally closed jumpers: no continuity reads one
// - Normally open jumpers invert contact sense
// - Contact state also drives external alarm
// - Counter counts each open/close transition
// - Counter clear write zeroes stroke counter
// - Time stroke from command to target switch
// - Alarm when stroke time exceeds limit
// - Stroke alarm drives alarm input block
// - Alarm latched until alarm clear written
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "vapc_defs.svh"

module vapc_top #(
	parameter int TICK_CYCLES = `VAPC_TICK_CYCLES,  // Clock cycles per timer tick
	parameter int CNT_W       = 32,                 // Stroke counter width
	parameter int TIME_W      = 16                  // Stroke time and limit width
) (
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	// APB slave
	input  wire logic                    psel_in,
	input  wire logic                    penable_in,
	input  wire logic                    pwrite_in,
	input  wire logic [`VAPC_ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]             pwdata_in,
	output logic      [31:0]             prdata_out,
	output logic                         pready_out,
	output logic                         pslverr_out,
	// Field pins
	input  wire logic                    upper_limit_switch_in,
	input  wire logic                    lower_limit_switch_in,
	input  wire logic                    aux_contact_terminals_in,
	input  wire logic                    polarity_jumper_a_in,
	input  wire logic                    polarity_jumper_b_in,
	output logic                         open_coil_terminals_out,
	output logic                         close_coil_terminals_out,
	// Function block facing results
	output logic                         closed_status_flag_out,
	output logic                         opened_status_flag_out,
	output logic [1:0]                   position_readback_out,
	output logic [1:0]                   process_value_out,
	output logic [1:0]                   backcalc_output_out,
	output logic                         alarm_input_block_out,
	output logic                         contact_input_block_out,
	output logic                         ext_alarm_out
);

	// ======================================================================
	// Pin synchronisation
	vapc_pin_if #(.W(5)) pins_if ();

	logic upper_sw;   // Upper switch, tripped at closed
	logic lower_sw;   // Lower switch, tripped at open
	logic aux_cont;   // High while the dry contact conducts
	logic jmp_a_no;   // Jumper A in normally-open position
	logic jmp_b_no;   // Jumper B in normally-open position

	assign pins_if.raw = {polarity_jumper_b_in, polarity_jumper_a_in, aux_contact_terminals_in,
		lower_limit_switch_in, upper_limit_switch_in};

	vapc_sync #(.W(5)) u_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.pins        (pins_if.sync_side)
	);

	assign upper_sw = pins_if.sync[0];
	assign lower_sw = pins_if.sync[1];
	assign aux_cont = pins_if.sync[2];
	assign jmp_a_no = pins_if.sync[3];
	assign jmp_b_no = pins_if.sync[4];

	// ======================================================================
	// APB slave
	logic                     access;       // Access phase in progress
	logic                     wr_fire;      // Write completes this edge
	logic                     addr_hit;     // Address maps to a register
	logic [31:0]              rd_data;      // Read mux output
	logic                     pready_r;     // Answer strobe
	logic                     pslverr_r;    // Error answer
	logic [31:0]              prdata_r;     // Captured read data

	logic [`VAPC_CTRL_W-1:0]  ctrl_r;       // Mode, invert, backcalc, auto bits
	logic [`VAPC_SETPT_W-1:0] setpt_r;      // Setpoints and manual outputs
	logic [TIME_W-1:0]        limit_r;      // Stroke time limit in ticks
	logic                     odo_clr;      // Counter clear request
	logic                     alm_clr;      // Alarm clear request

	assign access  = psel_in & penable_in;
	assign wr_fire = access & pready_r & pwrite_in & addr_hit;
	assign odo_clr = wr_fire & (paddr_in == `VAPC_OFF_CLEAR) & pwdata_in[`VAPC_CLR_ODOM];
	assign alm_clr = wr_fire & (paddr_in == `VAPC_OFF_CLEAR) & pwdata_in[`VAPC_CLR_ALARM];

	// Decode of mapped words; anything else answers with an error
	always_comb begin
		case (paddr_in)
			`VAPC_OFF_CTRL, `VAPC_OFF_SETPT, `VAPC_OFF_LIMIT, `VAPC_OFF_STATUS,
			`VAPC_OFF_ODOM, `VAPC_OFF_STROKE, `VAPC_OFF_CLEAR: begin
				addr_hit = 1'b1;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// One wait state: the answer is built from registers, so prdata stays a flop
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (access & ~pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= ~addr_hit;
			prdata_r  <= pwrite_in ? 32'h0000_0000 : rd_data;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Software-writable configuration
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r  <= `VAPC_CTRL_RST;
			setpt_r <= `VAPC_SETPT_RST;
			limit_r <= `VAPC_LIMIT_RST;
		end else if (wr_fire) begin
			case (paddr_in)
				`VAPC_OFF_CTRL:  ctrl_r  <= pwdata_in[`VAPC_CTRL_W-1:0];
				`VAPC_OFF_SETPT: setpt_r <= pwdata_in[`VAPC_SETPT_W-1:0];
				`VAPC_OFF_LIMIT: limit_r <= pwdata_in[TIME_W-1:0];
				default: begin
					// Read-only and clear words store nothing
				end
			endcase
		end
	end

	// ======================================================================
	// Output block values
	logic [1:0] blk_out_nxt;  // Next value of both output blocks
	logic [1:0] blk_out_r;    // Current value of both output blocks
	logic       cmd_new;      // Outputs change this edge
	logic       dual_mode;    // Dual coil operation selected
	logic       pulse_mode;   // Pulse drive selected

	assign dual_mode  = ctrl_r[`VAPC_CTRL_DUAL];
	assign pulse_mode = ctrl_r[`VAPC_CTRL_PULSE];

	// setpoint tracking, invert
	// Outside automatic mode the manual bits stand for the output directly
	always_comb begin
		blk_out_nxt[0] = ctrl_r[`VAPC_CTRL_AUTO0] ?
			(setpt_r[`VAPC_SETPT_SP0] ^ ctrl_r[`VAPC_CTRL_INV0]) : setpt_r[`VAPC_SETPT_MAN0];
		blk_out_nxt[1] = ctrl_r[`VAPC_CTRL_AUTO1] ?
			(setpt_r[`VAPC_SETPT_SP1] ^ ctrl_r[`VAPC_CTRL_INV1]) : setpt_r[`VAPC_SETPT_MAN1];
	end

	assign cmd_new = (blk_out_nxt != blk_out_r);

	// Registered copy used to spot a new command
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			blk_out_r <= 2'b00;
		end else begin
			blk_out_r <= blk_out_nxt;
		end
	end

	// ======================================================================
	// Timer tick
	logic [31:0] tick_cnt_r;  // Cycle count within one tick
	logic        tick_r;      // One-cycle tick pulse

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
			tick_r     <= 1'b0;
		end
	end

	// ======================================================================
	// Coil drive
	logic              open_coil_r;   // Open coil energised
	logic              close_coil_r;  // Close coil energised
	logic [TIME_W-1:0] pulse_cnt_r;   // Ticks since the pulse began
	logic              pulse_done;    // Pulse has run its length

	assign pulse_done = (pulse_cnt_r >= limit_r);

	// Pulse length counter, restarted by every new command
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_cnt_r <= '0;
		end else if (cmd_new) begin
			pulse_cnt_r <= '0;
		end else if (tick_r & ~pulse_done) begin
			pulse_cnt_r <= pulse_cnt_r + 1'b1;
		end
	end

	// Coil states; equal dual outputs must not disturb a held coil
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			open_coil_r  <= 1'b0;
			close_coil_r <= 1'b0;
		end else if (!dual_mode) begin
			open_coil_r  <= blk_out_nxt[0];
			close_coil_r <= blk_out_nxt[0];
		end else if (cmd_new && blk_out_nxt == 2'b01) begin
			open_coil_r  <= 1'b1;
			close_coil_r <= 1'b0;
		end else if (cmd_new && blk_out_nxt == 2'b10) begin
			open_coil_r  <= 1'b0;
			close_coil_r <= 1'b1;
		end else if (pulse_mode && pulse_done) begin
			open_coil_r  <= 1'b0;
			close_coil_r <= 1'b0;
		end
	end

	// ======================================================================
	// Switch readback and position flags
	logic [1:0]         rb_r;      // Readback pair, bit 0 upper, bit 1 lower
	logic [1:0]         bkcal_r;   // Back-calculation outputs
	vapc_pkg::vapc_pos_t pos_r;    // Decoded position

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rb_r <= 2'b00;
		end else begin
			rb_r <= {lower_sw, upper_sw};
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pos_r <= vapc_pkg::VAPC_POS_MOVING;
		end else begin
			case ({lower_sw, upper_sw})
				2'b01:   pos_r <= vapc_pkg::VAPC_POS_CLOSED;
				2'b10:   pos_r <= vapc_pkg::VAPC_POS_OPENED;
				2'b11:   pos_r <= vapc_pkg::VAPC_POS_BADADJ;
				default: pos_r <= vapc_pkg::VAPC_POS_MOVING;
			endcase
		end
	end

	// process value to backcalc
	// Without the option the back-calculation reports the block output instead
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bkcal_r <= 2'b00;
		end else begin
			bkcal_r[0] <= ctrl_r[`VAPC_CTRL_PVBK0] ? upper_sw : blk_out_r[0];
			bkcal_r[1] <= ctrl_r[`VAPC_CTRL_PVBK1] ? lower_sw : blk_out_r[1];
		end
	end

	// ======================================================================
	// Auxiliary dry contact
	logic contact_r;  // Contact input block value
	logic ext_alm_r;  // External alarm status

	// contact polarity
	// Only both jumpers in normally-open flip the sense; a mixed pair acts as normally closed
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			contact_r <= 1'b0;
			ext_alm_r <= 1'b0;
		end else begin
			contact_r <= (jmp_a_no & jmp_b_no) ? aux_cont : ~aux_cont;
			ext_alm_r <= (jmp_a_no & jmp_b_no) ? aux_cont : ~aux_cont;
		end
	end

	// ======================================================================
	// Stroke timing
	logic              timing_r;     // Stroke in progress
	logic              tgt_open_r;   // Commanded position is open
	logic [TIME_W-1:0] run_cnt_r;    // Ticks since the move command
	logic [TIME_W-1:0] stroke_r;     // Last published stroke time
	logic              move_cmd;     // A move command this edge
	logic              move_open;    // That command is toward open
	logic              stroke_done;  // Target switch reached
	logic              alarm_r;      // Latched stroke alarm
	logic              alarm_set;    // Stroke exceeded the limit

	// Single coil: energised means open; dual: only opposite outputs move
	assign move_cmd    = cmd_new & (~dual_mode | (blk_out_nxt[0] ^ blk_out_nxt[1]));
	assign move_open   = blk_out_nxt[0];
	assign stroke_done = timing_r & (tgt_open_r ? lower_sw : upper_sw);
	assign alarm_set   = timing_r & (run_cnt_r > limit_r);

	// stroke measurement
	// The running count saturates so a stuck valve never wraps to a short time
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timing_r   <= 1'b0;
			tgt_open_r <= 1'b0;
			run_cnt_r  <= '0;
			stroke_r   <= '0;
		end else if (move_cmd) begin
			timing_r   <= 1'b1;
			tgt_open_r <= move_open;
			run_cnt_r  <= '0;
		end else if (stroke_done) begin
			timing_r   <= 1'b0;
			stroke_r   <= run_cnt_r;
		end else if (timing_r && tick_r && run_cnt_r != '1) begin
			run_cnt_r  <= run_cnt_r + 1'b1;
		end
	end

	// latched alarm
	// A new overrun in the clearing cycle wins over the clear
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_r <= 1'b0;
		end else if (alarm_set) begin
			alarm_r <= 1'b1;
		end else if (alm_clr) begin
			alarm_r <= 1'b0;
		end
	end

	// ======================================================================
	// Stroke counter
	logic [CNT_W-1:0] odo_r;       // Completed strokes
	logic             end_valid_r; // A stroke has ended since reset
	logic             end_open_r;  // Last stroke ended open
	logic             odo_inc;     // Count this stroke

	assign odo_inc = stroke_done & (~end_valid_r | (end_open_r != tgt_open_r));

	// Last end position
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			end_valid_r <= 1'b0;
			end_open_r  <= 1'b0;
		end else if (stroke_done) begin
			end_valid_r <= 1'b1;
			end_open_r  <= tgt_open_r;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			odo_r <= '0;
		end else if (odo_clr) begin
			// A stroke ending with the clear is kept
			odo_r <= odo_inc ? CNT_W'(1) : '0;
		end else if (odo_inc && odo_r != '1) begin
			odo_r <= odo_r + 1'b1;
		end
	end

	// ======================================================================
	// Read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr_in)
			`VAPC_OFF_CTRL:   rd_data[`VAPC_CTRL_W-1:0]  = ctrl_r;
			`VAPC_OFF_SETPT:  rd_data[`VAPC_SETPT_W-1:0] = setpt_r;
			`VAPC_OFF_LIMIT:  rd_data[TIME_W-1:0]        = limit_r;
			`VAPC_OFF_STATUS: rd_data[11:0] = {timing_r, close_coil_r, open_coil_r, ext_alm_r,
				contact_r, alarm_r, pos_r, rb_r, rb_r[1], rb_r[0]};
			`VAPC_OFF_ODOM:   rd_data[CNT_W-1:0]         = odo_r;
			`VAPC_OFF_STROKE: rd_data[TIME_W-1:0]        = stroke_r;
			default: begin
				// Clear word and holes read as zero
			end
		endcase
	end

	// ======================================================================
	// Outputs, all from flip-flops
	assign prdata_out               = prdata_r;
	assign pready_out               = pready_r;
	assign pslverr_out              = pslverr_r;
	assign open_coil_terminals_out  = open_coil_r;
	assign close_coil_terminals_out = close_coil_r;
	assign closed_status_flag_out   = rb_r[0];
	assign opened_status_flag_out   = rb_r[1];
	assign position_readback_out    = rb_r;
	assign process_value_out        = rb_r;
	assign backcalc_output_out      = bkcal_r;
	assign alarm_input_block_out    = alarm_r;
	assign contact_input_block_out  = contact_r;
	assign ext_alarm_out            = ext_alm_r;

endmodule : vapc_top

// ### testbench/vapc_valve_model.sv
// Behavioural valve: pilot coils move the stem, two limit switches report it
`timescale 1ns/1ps

module vapc_valve_model #(
	parameter int TRAVEL = 40  // Cycles for a full stroke
) (
	input  wire logic core_clk_in,
	input  wire logic open_coil_in,   // Energised open pilot
	input  wire logic close_coil_in,  // Energised close pilot
	input  wire logic spring_in,      // Spring return to closed when unpowered
	input  wire logic stuck_in,       // Mis-set cams: both switches tripped
	output logic      upper_out,      // Tripped at closed
	output logic      lower_out       // Tripped at open
);
	// ======================================================================
	// Stem position, 0 closed and TRAVEL open
	int pos = 0;
	// Open pilot wins, so both pilots on drives toward open
	always @(posedge core_clk_in) begin
		if (open_coil_in && pos < TRAVEL) begin
			pos <= pos + 1;
		end else if ((close_coil_in || spring_in) && !open_coil_in && pos > 0) begin
			pos <= pos - 1;
		end
	end
	assign upper_out = stuck_in || pos == 0;
	assign lower_out = stuck_in || pos == TRAVEL;
endmodule : vapc_valve_model

// ### testbench/vapc_top_properties.sv
// Port-level assertions for the valve pilot block
`timescale 1ns/1ps
`include "vapc_defs.svh"

module vapc_top_props (
	input wire logic                    core_clk_in,
	input wire logic                    rst_in,
	input wire logic                    psel_in,
	input wire logic                    penable_in,
	input wire logic                    pwrite_in,
	input wire logic [`VAPC_ADDR_W-1:0] paddr_in,
	input wire logic [31:0]             pwdata_in,
	input wire logic                    pready_out,
	input wire logic                    upper_limit_switch_in,
	input wire logic                    lower_limit_switch_in,
	input wire logic                    aux_contact_terminals_in,
	input wire logic                    polarity_jumper_a_in,
	input wire logic                    polarity_jumper_b_in,
	input wire logic                    open_coil_terminals_out,
	input wire logic                    close_coil_terminals_out,
	input wire logic                    closed_status_flag_out,
	input wire logic                    opened_status_flag_out,
	input wire logic [1:0]              position_readback_out,
	input wire logic [1:0]              process_value_out,
	input wire logic                    alarm_input_block_out,
	input wire logic                    contact_input_block_out,
	input wire logic                    ext_alarm_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ======================================================================
	// Edges since reset: three-deep history is only trusted after four
	logic [2:0] up_r;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			up_r <= 3'h0;
		end else if (up_r != 3'h4) begin
			up_r <= up_r + 3'h1;
		end
	end
	wire wr_w  = psel_in & penable_in & pready_out & pwrite_in;  // Completed write
	wire clr_w = wr_w & (paddr_in == `VAPC_OFF_CLEAR) & pwdata_in[`VAPC_CLR_ALARM];
	// ======================================================================
	flag_pair_a: assert property (
		{closed_status_flag_out, opened_status_flag_out} == {position_readback_out[0],
		position_readback_out[1]}) else $error("status flags differ from readback");
	pv_copy_a: assert property (
		process_value_out == position_readback_out) else $error("process value not readback");
	closed_flag_a: assert property (
		up_r == 3'h4 |-> closed_status_flag_out == $past(upper_limit_switch_in, 3))
		else $error("closed flag does not follow upper switch");
	opened_flag_a: assert property (
		up_r == 3'h4 |-> opened_status_flag_out == $past(lower_limit_switch_in, 3))
		else $error("opened flag does not follow lower switch");
	contact_sense_a: assert property (
		up_r == 3'h4 |-> contact_input_block_out == ($past(aux_contact_terminals_in, 3)
		^ !($past(polarity_jumper_a_in, 3) && $past(polarity_jumper_b_in, 3))))
		else $error("contact input has wrong sense");
	ext_mirror_a: assert property (
		ext_alarm_out == contact_input_block_out) else $error("external alarm not contact");
	alarm_latch_a: assert property (
		$fell(alarm_input_block_out) |-> $past(clr_w) || $past(clr_w, 2))
		else $error("alarm dropped without clear");
	coil_cmd_a: assert property (
		$rose(open_coil_terminals_out) || $rose(close_coil_terminals_out)
		|-> $past(wr_w) || $past(wr_w, 2) || $past(wr_w, 3)) else $error("coil rose uncommanded");
endmodule : vapc_top_props

bind vapc_top vapc_top_props u_props (.*);

// ### testbench/vapc_top_tb.sv
// Self-checking bench for the valve pilot block
`timescale 1ns/1ps
`include "vapc_defs.svh"

`define VAPC_CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module vapc_top_tb;
	logic core_clk_in = 1'h0, rst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, err, aux_contact_terminals_in = 1'h0, spr = 1'h0, stk = 1'h0;
	logic polarity_jumper_a_in = 1'h0, polarity_jumper_b_in = 1'h0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, rd;
	logic [2:0] v;  // Jumper and contact pattern
	wire logic upper_limit_switch_in, lower_limit_switch_in, pready_out, pslverr_out;
	wire logic open_coil_terminals_out, close_coil_terminals_out, closed_status_flag_out;
	wire logic opened_status_flag_out, alarm_input_block_out, contact_input_block_out;
	wire logic ext_alarm_out;
	wire logic [31:0] prdata_out;
	wire logic [1:0] position_readback_out, process_value_out, backcalc_output_out;
	int fails = 0, tests_run = 0;
	// Short tick so a stroke of tens of cycles measures about ten ticks
	vapc_top #(.TICK_CYCLES(4)) u_dut (.*);
	vapc_valve_model u_valve (.core_clk_in(core_clk_in), .open_coil_in(open_coil_terminals_out),
		.close_coil_in(close_coil_terminals_out), .spring_in(spr), .stuck_in(stk),
		.upper_out(upper_limit_switch_in), .lower_out(lower_limit_switch_in));
	always #2 core_clk_in = ~core_clk_in;
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : cyc
	// One APB transfer; waits on pready, never a fixed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'h1;
		do @(posedge core_clk_in); while (pready_out !== 1'h1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'h0, a, 32'h0);
		`VAPC_CHK(nm, e, rd)
	endtask : rdchk
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	// Watchdog: the sequence needs about five hundred cycles
	initial begin
		#40000;
		fails++;
		conclude();
	end
	// ======================================================================
	// Test sequence
	initial begin
		cyc(20);
		rst_in <= 1'h0;
		rdchk(`VAPC_OFF_CTRL, 32'hC0, "ctrl");
		rdchk(`VAPC_OFF_LIMIT, 32'h1388, "limit");
		rdchk(8'h1C, 32'h0, "unmapped");
		`VAPC_CHK("slverr", 1'h1, err)
		$display("test reset done");
		spr <= 1'h1;
		apb(1'h1, `VAPC_OFF_LIMIT, 32'h64);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h1);
		cyc(2);
		`VAPC_CHK("coils", 2'h3, {open_coil_terminals_out, close_coil_terminals_out})
		cyc(60);
		`VAPC_CHK("flags", 2'h1, {closed_status_flag_out, opened_status_flag_out})
		rdchk(`VAPC_OFF_STATUS, 32'h7AA, "status");
		rdchk(`VAPC_OFF_ODOM, 32'h1, "odom");
		apb(1'h0, `VAPC_OFF_STROKE, 32'h0);
		`VAPC_CHK("stroke", 1'h1, rd >= 32'h9 && rd <= 32'hC)
		apb(1'h1, `VAPC_OFF_CTRL, 32'hC4);
		cyc(2);
		`VAPC_CHK("inverted", 2'h0, {open_coil_terminals_out, close_coil_terminals_out})
		cyc(60);
		`VAPC_CHK("flags", 2'h2, {closed_status_flag_out, opened_status_flag_out})
		rdchk(`VAPC_OFF_ODOM, 32'h2, "odom");
		apb(1'h1, `VAPC_OFF_CLEAR, 32'h1);
		rdchk(`VAPC_OFF_ODOM, 32'h0, "odom clear");
		// Process value on backcalc with invert off
		apb(1'h1, `VAPC_OFF_CTRL, 32'hD0);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h0);
		cyc(30);
		`VAPC_CHK("backcalc", 1'h1, backcalc_output_out[0])
		apb(1'h1, `VAPC_OFF_CTRL, 32'h0);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h4);
		cyc(2);
		`VAPC_CHK("manual", 2'h3, {open_coil_terminals_out, close_coil_terminals_out})
		$display("test single coil done");
		spr <= 1'h0;
		apb(1'h1, `VAPC_OFF_CTRL, 32'hCD);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h2);
		cyc(2);
		`VAPC_CHK("dual open", 2'h2, {open_coil_terminals_out, close_coil_terminals_out})
		apb(1'h1, `VAPC_OFF_SETPT, 32'h3);
		cyc(2);
		`VAPC_CHK("dual hold", 2'h2, {open_coil_terminals_out, close_coil_terminals_out})
		apb(1'h1, `VAPC_OFF_SETPT, 32'h0);
		cyc(2);
		`VAPC_CHK("dual hold", 2'h2, {open_coil_terminals_out, close_coil_terminals_out})
		apb(1'h1, `VAPC_OFF_SETPT, 32'h1);
		cyc(2);
		`VAPC_CHK("dual close", 2'h1, {open_coil_terminals_out, close_coil_terminals_out})
		cyc(60);
		$display("test dual constant done");
		apb(1'h1, `VAPC_OFF_CTRL, 32'hC3);
		apb(1'h1, `VAPC_OFF_LIMIT, 32'h3);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h1);
		cyc(24);
		`VAPC_CHK("pulse off", 2'h0, {open_coil_terminals_out, close_coil_terminals_out})
		`VAPC_CHK("alarm block", 1'h1, alarm_input_block_out)
		apb(1'h0, `VAPC_OFF_STATUS, 32'h0);
		`VAPC_CHK("alarm status", 1'h1, rd[6])
		apb(1'h1, `VAPC_OFF_CTRL, 32'hC1);
		apb(1'h1, `VAPC_OFF_LIMIT, 32'h64);
		apb(1'h1, `VAPC_OFF_SETPT, 32'h2);
		cyc(60);
		`VAPC_CHK("alarm held", 1'h1, alarm_input_block_out)
		apb(1'h1, `VAPC_OFF_CLEAR, 32'h2);
		cyc(3);
		`VAPC_CHK("alarm clear", 1'h0, alarm_input_block_out)
		$display("test pulse alarm done");
		for (int i = 0; i < 8; i++) begin
			v = 3'(i);
			{polarity_jumper_a_in, polarity_jumper_b_in, aux_contact_terminals_in} <= v;
			cyc(5);
			`VAPC_CHK("contact", v[0] ^ ~(v[2] & v[1]), contact_input_block_out)
			`VAPC_CHK("ext alarm", v[0] ^ ~(v[2] & v[1]), ext_alarm_out)
		end
		stk <= 1'h1;
		cyc(5);
		`VAPC_CHK("readback", 2'h3, position_readback_out)
		`VAPC_CHK("pv", 2'h3, process_value_out)
		rdchk(`VAPC_OFF_STATUS, 32'h5BF, "bad adjust");
		$display("test contact and switches done");
		conclude();
	end
endmodule : vapc_top_tb
